// ### synth_pkg.sv
// Shared constants and types for the dual integer-N synthesiser block.
package synth_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_DATA   = 8'hB2;
  localparam logic [7:0]  ADDR_CTRL   = 8'hB3;
  localparam logic [7:0]  ADDR_STAT   = 8'hB4;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [7:0]  RD_ZERO     = 8'h00;
  localparam int          CH_BYTE     = 8;
  localparam int          GAIN_BIT    = 3;
  localparam int          SET_BIT     = 1;
  localparam int          DW_CH_BIT   = 15;
  localparam int          DW_SET_BIT  = 14;
  localparam int          DW_SEL_LSB  = 12;
  localparam int          DW_PAY_W    = 12;
  localparam logic [1:0]  W_N_LO      = 2'h0;
  localparam logic [1:0]  W_N_HI      = 2'h1;
  localparam logic [1:0]  W_R_LO      = 2'h2;
  localparam logic [1:0]  W_R_HI      = 2'h3;

  // ---------------------------------------------------------------
  // Divider widths and lock tolerance in reference cycles
  // ---------------------------------------------------------------
  localparam int          N_W         = 20;
  localparam int          R_W         = 13;
  localparam logic [2:0]  TOL_ONE     = 3'h1;
  localparam logic [2:0]  TOL_FOUR    = 3'h4;
  localparam logic [2:0]  HIST_RST    = 3'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       ref_sel;
    logic [1:0] spare;
    logic       irq_en;
    logic       high_gain;
    logic       tol4;
    logic       set_sel;
    logic       enable;
  } chan_ctrl_t;

  typedef struct packed {
    logic [N_W-1:0] n;
    logic [R_W-1:0] r;
  } div_set_t;

  typedef struct packed {
    logic ref_div;
    logic fb_div;
  } cmp_edges_t;

  typedef enum logic [1:0] {
    LD_IDLE      = 2'b00,
    LD_REF_FIRST = 2'b01,
    LD_FB_FIRST  = 2'b10,
    LD_LATE      = 2'b11
  } ld_state_t;

  // A divider ratio of 0 or 1 passes every edge.
  function automatic logic at_term(input logic [N_W-1:0] cnt,
                                   input logic [N_W-1:0] div);
    return (div <= 20'h00001) || (cnt >= div - 20'h00001);
  endfunction : at_term

endpackage : synth_pkg

// ### synth_lock_detect.sv
// Lock detector for one synthesiser channel: window check and vote.
`timescale 1ns/100ps
module synth_lock_detect
  import synth_pkg::*;
(
  input  wire logic       i_core_clk, // Core clock.
  input  wire logic       i_reset,    // Synchronous reset, high.
  input  wire logic       i_clk_en,   // Freezes all state when low.
  input  wire logic       i_enable,   // Channel enabled.
  input  wire logic       i_tol4,     // Wide four-cycle window.
  input  wire logic       i_ref_tick, // Undivided reference edge.
  input  wire cmp_edges_t i_edges,    // Divided reference/feedback.
  output logic            o_locked,   // Voted lock status.
  output logic            o_loss      // Lock lost, one-cycle pulse.
);

  ld_state_t  st_r;
  ld_state_t  st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] hist_r;
  logic [2:0] hist_nxt;
  logic       lock_r;
  logic       lock_nxt;
  logic       loss_r;
  logic       meas_v;
  logic       meas_ok;
  logic       other_edge;
  logic [2:0] tol;

  assign tol        = i_tol4 ? TOL_FOUR : TOL_ONE;
  assign other_edge = (st_r == LD_REF_FIRST) ? i_edges.fb_div
                                             : i_edges.ref_div;

  // ---------------------------------------------------------------
  // One measurement per comparison cycle
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    meas_v  = 1'b0;
    meas_ok = 1'b0;
    unique case (st_r)
      LD_IDLE:
      begin
        cnt_nxt = 3'h0;
        if (i_edges.ref_div && i_edges.fb_div)
        begin
          meas_v  = 1'b1;
          meas_ok = 1'b1;
        end
        else if (i_edges.ref_div)
          st_nxt = LD_REF_FIRST;
        else if (i_edges.fb_div)
          st_nxt = LD_FB_FIRST;
      end
      LD_REF_FIRST, LD_FB_FIRST:
      begin
        if (other_edge)
        begin
          meas_v  = 1'b1;
          meas_ok = (cnt_r <= tol);
          st_nxt  = LD_IDLE;
        end
        else if (i_ref_tick)
        begin
          if (cnt_r == tol)
          begin
            meas_v = 1'b1;
            st_nxt = LD_LATE;
          end
          else
            cnt_nxt = cnt_r + 3'h1;
        end
      end
      LD_LATE:
        if (i_edges.ref_div || i_edges.fb_div)
          st_nxt = LD_IDLE;
    endcase
  end

  // The late edge of a failed pair is swallowed in LD_LATE so that a
  // slipping loop scores one miss per cycle, not two.
  assign hist_nxt = meas_v ? {hist_r[1:0], meas_ok} : hist_r;
  assign lock_nxt = lock_r ? ((hist_nxt[0] & hist_nxt[1]) |
                              (hist_nxt[1] & hist_nxt[2]) |
                              (hist_nxt[0] & hist_nxt[2]))
                           : (hist_nxt[0] & hist_nxt[1]);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset || (i_clk_en && !i_enable))
    begin
      st_r   <= LD_IDLE;
      cnt_r  <= 3'h0;
      hist_r <= HIST_RST;
      lock_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      hist_r <= hist_nxt;
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      loss_r <= 1'b0;
    else if (i_clk_en)
      loss_r <= i_enable & lock_r & ~lock_nxt;
  end

  assign o_locked = lock_r;
  assign o_loss   = loss_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  lock_needs_pair_a: assert property (
    $rose(lock_r) |-> hist_r[1:0] == 2'b11)
    else $error("lock rose without two successive good measurements");
  lock_majority_a: assert property (
    lock_r |-> (hist_r[0] + hist_r[1] + hist_r[2]) >= 2)
    else $error("lock held without majority of history");
  window_miss_a: assert property (
    i_clk_en && i_enable && st_r == LD_REF_FIRST && !i_edges.fb_div
    && i_ref_tick && cnt_r == tol |=> st_r == LD_LATE && !hist_r[0])
    else $error("edge outside tolerance not scored as a miss");
  loss_pulse_a: assert property (
    $fell(lock_r) && $past(i_enable) |-> loss_r)
    else $error("lock loss not reported");
  disabled_unlocked_a: assert property (
    i_clk_en && !i_enable |=> !lock_r && hist_r == HIST_RST)
    else $error("disabled channel shows lock");

  lock_gained_c: cover property ($rose(lock_r));
  lock_lost_c:   cover property (loss_r);

endmodule : synth_lock_detect

// ### integer_n_synth_divider_lock_detect.sv
// Two integer-N synthesiser channels with register access and lock.
`timescale 1ns/100ps
module integer_n_synth_divider_lock_detect
  import synth_pkg::*;
(
  input  wire logic        i_core_clk,            // Core clock, 40 MHz.
  input  wire logic        i_reset,               // Sync reset, high.
  input  wire logic        i_clk_en,              // Freeze when low.
  input  wire logic        i_wr_en,               // Register write.
  input  wire logic        i_rd_en,               // Register read.
  input  wire logic [7:0]  i_addr,                // Register address.
  input  wire logic [15:0] i_wr_data,             // Write data.
  output logic      [7:0]  o_rd_data,             // Read data.
  input  wire logic        i_xtal_ref,            // Crystal reference.
  input  wire logic        i_synth_ref_clock_pin, // Reference pin.
  input  wire logic [1:0]  i_vco_fb,              // VCO feedback.
  output logic      [1:0]  o_cp_up,               // Pump up.
  output logic      [1:0]  o_cp_down,             // Pump down.
  output logic      [1:0]  o_cp_high_gain,        // Gain select.
  output logic             o_lock_irq             // Lock loss irq.
);

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [3:0]     meta_r;
  logic [3:0]     sync_r;
  logic [1:0]     prev_r;
  logic           ref_lvl;
  logic           ref_prev_r;
  logic           ref_tick;
  logic [1:0]     fb_tick;
  logic [15:0]    ctrl_r;
  chan_ctrl_t     cc [2];
  div_set_t       sets_r [2][2];
  div_set_t       act [2];
  logic [R_W-1:0] r_cnt_r [2];
  logic [N_W-1:0] n_cnt_r [2];
  logic [1:0]     ref_div;
  logic [1:0]     fb_div;
  logic [1:0]     locked;
  logic [1:0]     loss;
  logic [1:0]     loss_r;
  logic [1:0]     up_r;
  logic [1:0]     down_r;
  logic [7:0]     rd_r;
  logic           wr_data;
  logic           wr_ctrl;
  logic           rd_stat;
  logic           wr_ch;
  logic           wr_set;
  logic [1:0]     wr_sel;
  logic [DW_PAY_W-1:0] wr_pay;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      meta_r <= 4'h0;
      sync_r <= 4'h0;
      prev_r <= 2'h0;
    end
    else if (i_clk_en)
    begin
      meta_r <= {i_vco_fb, i_synth_ref_clock_pin, i_xtal_ref};
      sync_r <= meta_r;
      prev_r <= sync_r[3:2];
    end
  end

  // Changing the source may create one stray edge; retune afterwards.
  assign ref_lvl  = cc[0].ref_sel ? sync_r[1] : sync_r[0];
  assign ref_tick = ref_lvl & ~ref_prev_r;
  assign fb_tick  = sync_r[3:2] & ~prev_r;

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      ref_prev_r <= 1'b0;
    else if (i_clk_en)
      ref_prev_r <= ref_lvl;
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  assign wr_data = i_clk_en && i_wr_en && (i_addr == ADDR_DATA);
  assign wr_ctrl = i_clk_en && i_wr_en && (i_addr == ADDR_CTRL);
  assign rd_stat = i_clk_en && i_rd_en && (i_addr == ADDR_STAT);
  assign wr_ch   = i_wr_data[DW_CH_BIT];
  assign wr_set  = i_wr_data[DW_SET_BIT];
  assign wr_sel  = i_wr_data[DW_SEL_LSB +: 2];
  assign wr_pay  = i_wr_data[DW_PAY_W-1:0];

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= i_wr_data;
  end

  // No interlock: a write to the live set is applied at once.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      for (int c = 0; c < 2; c++)
        for (int s = 0; s < 2; s++)
          sets_r[c][s] <= '0;
    end
    else if (wr_data)
    begin
      unique case (wr_sel)
        W_N_LO: sets_r[wr_ch][wr_set].n[DW_PAY_W-1:0] <= wr_pay;
        W_N_HI: sets_r[wr_ch][wr_set].n[N_W-1:DW_PAY_W] <=
                  wr_pay[N_W-DW_PAY_W-1:0];
        W_R_LO: sets_r[wr_ch][wr_set].r[DW_PAY_W-1:0] <= wr_pay;
        W_R_HI: sets_r[wr_ch][wr_set].r[R_W-1] <= wr_pay[0];
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_ch
    assign cc[ch]  = chan_ctrl_t'(ctrl_r[ch*CH_BYTE +: CH_BYTE]);
    assign act[ch] = sets_r[ch][cc[ch].set_sel];
    assign o_cp_high_gain[ch] = cc[ch].high_gain;

    // R divides the reference down to the comparison rate and N
    // divides the VCO down to it, so the loop settles at ref*N/R.
    assign ref_div[ch] = cc[ch].enable && ref_tick &&
      at_term(N_W'(r_cnt_r[ch]), N_W'(act[ch].r));
    assign fb_div[ch]  = cc[ch].enable && fb_tick[ch] &&
      at_term(n_cnt_r[ch], act[ch].n);

    always_ff @(posedge i_core_clk)
    begin
      if (i_reset || (i_clk_en && !cc[ch].enable))
      begin
        r_cnt_r[ch] <= '0;
        n_cnt_r[ch] <= '0;
      end
      else if (i_clk_en)
      begin
        if (ref_div[ch])
          r_cnt_r[ch] <= '0;
        else if (ref_tick)
          r_cnt_r[ch] <= r_cnt_r[ch] + 13'h0001;
        if (fb_div[ch])
          n_cnt_r[ch] <= '0;
        else if (fb_tick[ch])
          n_cnt_r[ch] <= n_cnt_r[ch] + 20'h00001;
      end
    end

    // Phase-frequency detector: both pulses pending cancel out.
    always_ff @(posedge i_core_clk)
    begin
      if (i_reset || (i_clk_en && !cc[ch].enable))
      begin
        up_r[ch]   <= 1'b0;
        down_r[ch] <= 1'b0;
      end
      else if (i_clk_en)
      begin
        if ((up_r[ch] || ref_div[ch]) && (down_r[ch] || fb_div[ch]))
        begin
          up_r[ch]   <= 1'b0;
          down_r[ch] <= 1'b0;
        end
        else
        begin
          up_r[ch]   <= up_r[ch] | ref_div[ch];
          down_r[ch] <= down_r[ch] | fb_div[ch];
        end
      end
    end

    synth_lock_detect u_lock (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_clk_en   (i_clk_en),
      .i_enable   (cc[ch].enable),
      .i_tol4     (cc[ch].tol4),
      .i_ref_tick (ref_tick),
      .i_edges    ({ref_div[ch], fb_div[ch]}),
      .o_locked   (locked[ch]),
      .o_loss     (loss[ch])
    );
  end

  assign o_cp_up   = up_r;
  assign o_cp_down = down_r;

  // ---------------------------------------------------------------
  // Status, loss flags and interrupt
  // ---------------------------------------------------------------
  // A loss in the same cycle as the clearing read survives it.
  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      loss_r <= 2'b00;
    else if (i_clk_en)
      loss_r <= (loss_r & ~{2{rd_stat}}) | loss;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
      rd_r <= RD_ZERO;
    else if (rd_stat)
      rd_r <= {4'h0, loss_r, locked};
    else if (i_clk_en && i_rd_en)
      rd_r <= RD_ZERO;
  end

  assign o_rd_data  = rd_r;
  assign o_lock_irq = |(loss_r & {cc[1].irq_en, cc[0].irq_en});

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  gain_bits_a: assert property (
    wr_ctrl |=> o_cp_high_gain ==
      {$past(i_wr_data[CH_BYTE+GAIN_BIT]), $past(i_wr_data[GAIN_BIT])})
    else $error("gain select not taken from control bits");
  set_swap_a: assert property (
    wr_ctrl |=> act[0] == sets_r[0][$past(i_wr_data[SET_BIT])])
    else $error("active divider set not switched by control write");
  live_write_a: assert property (
    wr_data && wr_sel == W_N_LO && !wr_ch && !wr_set
    |=> sets_r[0][0].n[DW_PAY_W-1:0] == $past(wr_pay))
    else $error("divider write not applied at once");
  loss_sticky_a: assert property (
    i_clk_en && loss[0] |=> loss_r[0])
    else $error("lock loss event dropped");
  irq_masked_a: assert property (
    i_clk_en && |(loss & {cc[1].irq_en, cc[0].irq_en}) && !wr_ctrl
    |=> o_lock_irq)
    else $error("unmasked lock loss did not interrupt");
  ref_divide_a: assert property (
    // A live write that drops R below the running count wraps at the
    // next reference edge, so that case is left out.
    ref_div[0] && act[0].r > 13'h0001 && r_cnt_r[0] < act[0].r
    |-> r_cnt_r[0] == act[0].r - 13'h0001)
    else $error("reference divider fired off terminal count");

  swap_c:     cover property (wr_ctrl && i_wr_data[SET_BIT] != cc[0].set_sel);
  irq_c:      cover property ($rose(o_lock_irq));
  both_lock_c: cover property (locked == 2'b11);

endmodule : integer_n_synth_divider_lock_detect

// ### vco_loop_model.sv
// Behavioural VCO and loop filter that answer pump-up requests.
`timescale 1ns/100ps
module vco_loop_model
(
  input  wire logic       i_core_clk, // Core clock.
  input  wire logic       i_ref,      // Undivided reference.
  input  wire logic       i_cp_up,    // Pump up from the device.
  input  wire logic [2:0] i_late,     // Reference rises to lag by.
  output logic            o_fb        // Divided feedback edge.
);
  logic       up_q  = 1'b0;
  logic       ref_q = 1'b0;
  logic       armed = 1'b0;
  logic [2:0] rises = 3'h0;
  logic [2:0] hold  = 3'h0;

  assign o_fb = (hold != 3'h0);

  // Each pump-up request is answered at the reference fall that follows
  // i_late further reference rises, so the phase error is exact.
  always @(posedge i_core_clk)
  begin
    up_q  <= i_cp_up;
    ref_q <= i_ref;
    if (hold != 3'h0)
      hold <= hold - 3'h1;
    if (i_cp_up && !up_q)
    begin
      armed <= 1'b1;
      rises <= 3'h0;
    end
    else if (armed)
    begin
      if (i_ref && !ref_q)
        rises <= rises + 3'h1;
      if (!i_ref && ref_q && rises >= i_late)
      begin
        armed <= 1'b0;
        hold  <= 3'h4;
      end
    end
  end
endmodule : vco_loop_model

// ### integer_n_synth_divider_lock_detect_tb.sv
// Self-checking testbench for the dual synthesiser block.
`timescale 1ns/100ps
module integer_n_synth_divider_lock_detect_tb;
  import synth_pkg::*;

  logic        i_core_clk = 1'b0;
  logic        i_reset    = 1'b1;
  logic        clk_en     = 1'b1;
  logic        i_wr_en    = 1'b0;
  logic        i_rd_en    = 1'b0;
  logic [7:0]  i_addr     = 8'h00;
  logic [15:0] i_wr_data  = 16'h0000;
  logic        xtal       = 1'b0;
  logic        pin        = 1'b0;
  logic [4:0]  phase      = 5'h00;
  logic [2:0]  late [2]   = '{3'h0, 3'h3};
  logic [7:0]  o_rd_data;
  logic [1:0]  fb;
  logic [1:0]  o_cp_up;
  logic [1:0]  o_cp_down;
  logic [1:0]  o_cp_high_gain;
  logic        o_lock_irq;
  logic [7:0]  rd;
  int          fail_count = 0;
  int          n_checks   = 0;

  always #12.5 i_core_clk = ~i_core_clk;

  // Crystal reference has a 16-cycle period, the pin a 32-cycle one.
  always @(posedge i_core_clk)
  begin
    phase <= phase + 5'h01;
    xtal  <= phase[3];
    pin   <= phase[4];
  end

  integer_n_synth_divider_lock_detect i_integer_n_synth_divider_lock_detect
  (
    .i_core_clk            (i_core_clk),
    .i_reset               (i_reset),
    .i_clk_en              (clk_en),
    .i_wr_en               (i_wr_en),
    .i_rd_en               (i_rd_en),
    .i_addr                (i_addr),
    .i_wr_data             (i_wr_data),
    .o_rd_data             (o_rd_data),
    .i_xtal_ref            (xtal),
    .i_synth_ref_clock_pin (pin),
    .i_vco_fb              (fb),
    .o_cp_up               (o_cp_up),
    .o_cp_down             (o_cp_down),
    .o_cp_high_gain        (o_cp_high_gain),
    .o_lock_irq            (o_lock_irq)
  );

  vco_loop_model i_vco_loop_model_0
  (
    .i_core_clk (i_core_clk),
    .i_ref      (xtal),
    .i_cp_up    (o_cp_up[0]),
    .i_late     (late[0]),
    .o_fb       (fb[0])
  );

  vco_loop_model i_vco_loop_model_1
  (
    .i_core_clk (i_core_clk),
    .i_ref      (xtal),
    .i_cp_up    (o_cp_up[1]),
    .i_late     (late[1]),
    .o_fb       (fb[1])
  );

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
    i_wr_en   <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_core_clk);
    i_rd_en <= 1'b0;
    @(posedge i_core_clk);
    #1;
    rd = o_rd_data;
  endtask : reg_rd

  task automatic setdiv(input logic ch, input logic set,
                        input logic [19:0] n, input logic [12:0] r);
    reg_wr(ADDR_DATA, {ch, set, W_N_LO, n[11:0]});
    reg_wr(ADDR_DATA, {ch, set, W_N_HI, 4'h0, n[19:12]});
    reg_wr(ADDR_DATA, {ch, set, W_R_LO, r[11:0]});
    reg_wr(ADDR_DATA, {ch, set, W_R_HI, 11'h000, r[12]});
  endtask : setdiv

  // Returns the cycles from now to the next rising pump-up request.
  task automatic wait_up(input int ch, output int n);
    n = 0;
    while (o_cp_up[ch] !== 1'b0 && n < 400)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    while (o_cp_up[ch] !== 1'b1 && n < 800)
    begin
      @(posedge i_core_clk);
      #1;
      n++;
    end
    if (n >= 800)
    begin
      $display("unexpected pump request timeout on channel %0d", ch);
      fail_count++;
      test_done();
    end
  endtask : wait_up

  task automatic settle(input int ch, input int cycles);
    int n;
    wait_up(ch, n);
    repeat (cycles) @(posedge i_core_clk);
  endtask : settle

  task automatic measure(input int ch, input int exp, input string name);
    int n;
    wait_up(ch, n);
    wait_up(ch, n);
    wait_up(ch, n);
    check(name, n[15:0], exp[15:0]);
    check({name, " down"}, {14'h0, o_cp_down}, 16'h0000);
  endtask : measure

  initial
  begin
    repeat (8) @(posedge i_core_clk);
    i_reset <= 1'b0;
    reg_rd(ADDR_STAT);
    check("status after reset", {8'h00, rd}, 16'h0000);
    check("irq after reset", {15'h0, o_lock_irq}, 16'h0000);
    check("pump after reset", {12'h0, o_cp_up, o_cp_down}, 16'h0000);
    reg_rd(8'hB5);
    check("unmapped read", {8'h00, rd}, 16'h0000);
    reg_wr(ADDR_CTRL, 16'h0808);
    #1;
    check("gain both", {14'h0, o_cp_high_gain}, 16'h0003);
    reg_wr(ADDR_CTRL, 16'h0800);
    #1;
    check("gain ch1", {14'h0, o_cp_high_gain}, 16'h0002);
    @(posedge i_core_clk);
    clk_en <= 1'b0;
    reg_wr(ADDR_CTRL, 16'h0008);
    clk_en <= 1'b1;
    #1;
    check("frozen write", {14'h0, o_cp_high_gain}, 16'h0002);
    $display("test reset and gain done");

    setdiv(1'b0, 1'b0, 20'h00001, 13'h0008);
    setdiv(1'b1, 1'b0, 20'h00001, 13'h0008);
    setdiv(1'b0, 1'b1, 20'h00001, 13'h0004);
    reg_wr(ADDR_CTRL, 16'h0511);
    settle(0, 40);
    reg_rd(ADDR_STAT);
    check("lock0 after one", {15'h0, rd[0]}, 16'h0000);
    settle(0, 40);
    reg_rd(ADDR_STAT);
    check("lock0 after two", {15'h0, rd[0]}, 16'h0001);
    repeat (3) settle(1, 100);
    reg_rd(ADDR_STAT);
    check("both locked", {8'h00, rd}, 16'h0003);
    $display("test lock done");

    reg_wr(ADDR_CTRL, 16'h0111);
    settle(1, 100);
    reg_rd(ADDR_STAT);
    check("lock1 one miss", {15'h0, rd[1]}, 16'h0001);
    settle(1, 100);
    check("masked irq", {15'h0, o_lock_irq}, 16'h0000);
    reg_rd(ADDR_STAT);
    check("loss ch1", {8'h00, rd}, 16'h0009);
    reg_rd(ADDR_STAT);
    check("loss cleared", {8'h00, rd}, 16'h0001);
    late[0] <= 3'h6;
    settle(0, 100);
    reg_rd(ADDR_STAT);
    check("lock0 one miss", {15'h0, rd[0]}, 16'h0001);
    settle(0, 100);
    check("loss irq", {15'h0, o_lock_irq}, 16'h0001);
    reg_rd(ADDR_STAT);
    check("loss ch0", {8'h00, rd}, 16'h0004);
    check("irq cleared", {15'h0, o_lock_irq}, 16'h0000);
    $display("test loss done");

    late[0] <= 3'h0;
    measure(0, 128, "period set0");
    reg_wr(ADDR_CTRL, 16'h0113);
    measure(0, 64, "period set1");
    reg_wr(ADDR_DATA, {2'b01, W_R_LO, 12'h002});
    measure(0, 32, "live write");
    reg_wr(ADDR_CTRL, 16'h0193);
    measure(0, 64, "pin ref ch0");
    measure(1, 256, "pin ref ch1");
    $display("test sets and reference done");
    test_done();
  end
endmodule : integer_n_synth_divider_lock_detect_tb
